// *** dv/pmicir_host.sv ***
// host model for the register strobe port
`timescale 1ns/1ps
`default_nettype none
`include "pmicir_consts.svh"
module pmicir_host (
   // clock
   input wire logic core_clk,
   // register port
   output logic [7:0] reg_addr,
   output logic [7:0] reg_wdata,
   output logic reg_wr,
   output logic reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic reg_rvalid
);
   initial begin
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
   end
   // released lines show the inverse, never a stale value
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
      reg_addr <= ~a;
      reg_wdata <= ~d;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d,
                     output logic ok);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      reg_addr <= ~a;
      ok = 1'b0;
      d = 8'h00;
      for (int i = 0; i < 4 && !ok; i++) begin
         @(posedge core_clk);
         if (reg_rvalid === 1'b1) begin
            ok = 1'b1;
            d = reg_rdata;
         end
      end
   endtask
   task automatic restore();
      wr(`PMICIR_ADDR_RESTORE, `PMICIR_RESTORE_KEY);
   endtask
endmodule // pmicir_host
`default_nettype wire

// *** dv/tb.sv ***
// self-checking bench for the interrupt register block
`timescale 1ns/1ps
`default_nettype none
`include "pmicir_consts.svh"
module tb;
   localparam int TPS = 4;
   logic core_clk = 1'b0;
   logic rstn = 1'b0;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, chg_event_in;
   logic reg_wr, reg_rd, reg_rvalid, dog_expired, irq_out;
   logic [2:0] bl_event_in = 3'h0;
   logic die_temp_warn = 1'b0, dog_period_64 = 1'b0, dog_kick = 1'b0;
   logic external_thermistor_mode = 1'b0, thermistor_47k_active;
   int error_cnt = 0, n_tests = 0, cyc = 0;
   initial chg_event_in = 8'h00;
   always #4 core_clk = ~core_clk;
   pmicir_host host (.core_clk(core_clk), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));
   pmicir_top #(.TICKS_PER_SEC(TPS)) dut (.core_clk(core_clk),
      .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .reg_rvalid(reg_rvalid), .chg_event_in(chg_event_in),
      .die_temp_warn(die_temp_warn), .bl_event_in(bl_event_in),
      .dog_period_64(dog_period_64), .dog_kick(dog_kick),
      .dog_expired(dog_expired),
      .external_thermistor_mode(external_thermistor_mode),
      .thermistor_47k_active(thermistor_47k_active), .irq_out(irq_out));
   task automatic test_done();
      $display("tests %0d errors %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 3000) begin
         error_cnt++;
         test_done();
      end
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         error_cnt++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] d;
      logic ok;
      host.rd(a, d, ok);
      chk(ok ? d : 'x, exp);
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
   endtask
   // 0x38..0x3F, select register alone resets to one
   task automatic t_defaults();
      for (int i = 0; i < 8; i++) begin
         rchk(8'h38 + 8'(i), (i == 5) ? 8'h01 : 8'h00);
      end
      $display("done defaults");
   endtask
   task automatic t_chg();
      @(posedge core_clk);
      dog_kick <= 1'b1;
      @(posedge core_clk);
      dog_kick <= 1'b0;
      host.wr(`PMICIR_ADDR_CHG_EN, 8'hFF);
      rchk(`PMICIR_ADDR_CHG_EN, 8'hFF);
      @(posedge core_clk);
      chg_event_in <= 8'hFF;
      die_temp_warn <= 1'b1;
      @(posedge core_clk);
      chg_event_in <= 8'h00;
      tick(3);
      chk({7'h00, irq_out}, 8'h01);
      rchk(`PMICIR_ADDR_CHG_FLAG, 8'hDF);
      tick(1);
      chk({7'h00, irq_out}, 8'h00);
      rchk(`PMICIR_ADDR_CHG_FLAG, 8'h00);
      host.wr(`PMICIR_ADDR_CHG_EN, 8'h00);
      @(posedge core_clk);
      chg_event_in <= 8'hCF;
      die_temp_warn <= 1'b0;
      @(posedge core_clk);
      chg_event_in <= 8'h00;
      tick(3);
      chk({7'h00, irq_out}, 8'h00);
      rchk(`PMICIR_ADDR_CHG_FLAG, 8'h00);
      $display("done charger events");
   endtask
   task automatic t_bl();
      @(posedge core_clk);
      bl_event_in <= 3'h7;
      @(posedge core_clk);
      bl_event_in <= 3'h0;
      host.wr(`PMICIR_ADDR_BL_FLAG, 8'hFF);
      rchk(`PMICIR_ADDR_BL_FLAG, 8'h00);
      host.wr(`PMICIR_ADDR_BL_EN, 8'hFF);
      rchk(`PMICIR_ADDR_BL_EN, 8'h07);
      @(posedge core_clk);
      bl_event_in <= 3'h7;
      @(posedge core_clk);
      bl_event_in <= 3'h0;
      tick(3);
      chk({7'h00, irq_out}, 8'h01);
      rchk(`PMICIR_ADDR_BL_FLAG, 8'h07);
      rchk(`PMICIR_ADDR_BL_FLAG, 8'h00);
      chk({7'h00, irq_out}, 8'h00);
      $display("done boost ldo events");
   endtask
   task automatic t_ntc();
      external_thermistor_mode <= 1'b1;
      tick(2);
      chk({7'h00, thermistor_47k_active}, 8'h01);
      host.wr(`PMICIR_ADDR_NTC, 8'hFE);
      tick(2);
      chk({7'h00, thermistor_47k_active}, 8'h00);
      rchk(`PMICIR_ADDR_NTC, 8'h00);
      host.wr(`PMICIR_ADDR_NTC, 8'hFF);
      rchk(`PMICIR_ADDR_NTC, 8'h01);
      external_thermistor_mode <= 1'b0;
      tick(2);
      chk({7'h00, thermistor_47k_active}, 8'h00);
      $display("done thermistor select");
   endtask
   task automatic t_restore();
      host.wr(`PMICIR_ADDR_CHG_EN, 8'hA5);
      host.wr(`PMICIR_ADDR_NTC, 8'h00);
      @(posedge core_clk);
      chg_event_in <= 8'h80;
      @(posedge core_clk);
      chg_event_in <= 8'h00;
      host.wr(`PMICIR_ADDR_RESTORE, 8'h7E);
      rchk(`PMICIR_ADDR_CHG_EN, 8'hA5);
      chk({7'h00, irq_out}, 8'h01);
      host.restore();
      tick(3);
      chk({7'h00, irq_out}, 8'h00);
      t_defaults();
      $display("done restore");
   endtask
   task automatic t_dog(input logic p64);
      int per, lead, n;
      logic [7:0] d;
      logic ok;
      per = (p64 ? 64 : 32) * TPS;
      lead = (p64 ? 4 : 2) * TPS;
      n = 0;
      dog_period_64 <= p64;
      host.wr(`PMICIR_ADDR_CHG_EN, 8'h20);
      @(posedge core_clk);
      dog_kick <= 1'b1;
      @(posedge core_clk);
      dog_kick <= 1'b0;
      host.rd(`PMICIR_ADDR_CHG_FLAG, d, ok);
      repeat (per - lead - 12) begin
         @(posedge core_clk);
         if (dog_expired === 1'b1) n++;
      end
      rchk(`PMICIR_ADDR_CHG_FLAG, 8'h00);
      repeat (lead + 12) begin
         @(posedge core_clk);
         if (dog_expired === 1'b1) n++;
      end
      rchk(`PMICIR_ADDR_CHG_FLAG, 8'h20);
      chk(8'(n), 8'h01);
      $display("done watchdog alarm");
   endtask
   initial begin
      tick(3);
      rstn <= 1'b1;
      t_defaults();
      t_chg();
      t_bl();
      t_ntc();
      t_restore();
      t_dog(1'b0);
      t_dog(1'b1);
      test_done();
   end
endmodule // tb
`default_nettype wire

// *** inc/pmicir_consts.svh ***
// constants for the charger and boost/ldo interrupt register block
// Functional notes
// (RULE1) The charger enable register holds one enable per source: 7 coil peak, 6 isothermal, 5 watchdog alarm, 4 overtemperature, 3 thermistor, 2 cell voltage, 1 mode change, 0 input voltage.
// (RULE2) All charger enable bits are read/write and reset to zero, so no charger source is enabled at start.
// (RULE3) The charger flag register holds one read-only flag per source at the enable positions, set when that event causes an interrupt, reset to zero.
// (RULE4) Every flag of both flag registers clears itself when the host reads its register.
// (RULE5) The watchdog alarm rises 2 s before expiry with a 32 s period and 4 s before expiry with a 64 s period.
// (RULE6) The overtemperature source is the 130 C die warning and is gated by its enable bit.
// (RULE7) The boost/LDO enable register uses bit 2 led open, bit 1 boost power good, bit 0 regulator 1 power good; 1 passes, 0 blocks, reset 0.
// (RULE8) The boost/LDO flag register sets bit 2 on led open, bit 1 on boost power good warning, bit 0 on regulator 1 warning; bits 7 to 3 read zero.
// (RULE9) Writing 0x7F to the write-only restore register returns every register to its default.
// (RULE10) The thermistor select bit 0, reset 1, picks 47 kohm at 1 and 100 kohm at 0, effective only while external thermistor mode is 1.
// (RULE11) The interrupt output is high while any enabled flag is pending and drops once all are read away.
`ifndef PMICIR_CONSTS_SVH
`define PMICIR_CONSTS_SVH

`define PMICIR_ADDR_CHG_EN 8'h38
`define PMICIR_ADDR_CHG_FLAG 8'h39
`define PMICIR_ADDR_BL_EN 8'h3A
`define PMICIR_ADDR_BL_FLAG 8'h3B
`define PMICIR_ADDR_RESTORE 8'h3C
`define PMICIR_ADDR_NTC 8'h3D

`define PMICIR_RESTORE_KEY 8'h7F
`define PMICIR_RST_CHG_EN 8'h00
`define PMICIR_RST_BL_EN 3'h0
`define PMICIR_RST_NTC 1'h1

`define PMICIR_CHG_W 8
`define PMICIR_BL_W 3
`define PMICIR_BIT_DOG 5
`define PMICIR_BIT_OVT 4

`define PMICIR_CLK_HZ 125000000
`define PMICIR_DOG_P32_SEC 7'h20
`define PMICIR_DOG_P64_SEC 7'h40
`define PMICIR_DOG_LEAD32_SEC 7'h02
`define PMICIR_DOG_LEAD64_SEC 7'h04

`endif

// *** inc/pmicir_pkg.sv ***
// types shared by the interrupt register block
package pmicir_pkg;
   typedef enum logic [1:0] {
      PMICIR_ST_RUN = 2'b01,
      PMICIR_ST_RESTORE = 2'b10
   } pmicir_state_t;
endpackage

// *** src/pmicir_flags.sv ***
// bank of sticky clear-on-read event flags
`timescale 1ns/1ps
`default_nettype none
module pmicir_flags #(
   parameter int W = 8
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic rstn,
   // control
   input wire logic [W-1:0] set_in,
   input wire logic clr_in,
   // state
   output logic [W-1:0] flags
);
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         flags <= '0;
      end else begin
         // a set in the clearing cycle survives
         flags <= (clr_in ? '0 : flags) | set_in; // RULE4
      end
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rstn);

   chk_set_survives: assert property ( // RULE4
      (set_in != '0) |=> ((flags & $past(set_in)) == $past(set_in)))
      else $error("flag set lost");
   chk_clear_on_read: assert property ( // RULE4
      (clr_in && set_in == '0) |=> (flags == '0))
      else $error("flag not cleared by read");
endmodule // pmicir_flags
`default_nettype wire

// *** src/pmicir_top.sv ***
// charger and boost/ldo interrupt registers, watchdog alarm, restore
`timescale 1ns/1ps
`default_nettype none
`include "pmicir_consts.svh"
module pmicir_top #(
   parameter int TICKS_PER_SEC = `PMICIR_CLK_HZ
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic rstn,
   // register access from the serial interface
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   output logic reg_rvalid,
   // charger event pulses, bits 5 and 4 unused here
   input wire logic [7:0] chg_event_in,
   input wire logic die_temp_warn,
   // boost/ldo event pulses
   input wire logic [2:0] bl_event_in,
   // watchdog
   input wire logic dog_period_64,
   input wire logic dog_kick,
   output logic dog_expired,
   // thermistor
   input wire logic external_thermistor_mode,
   output logic thermistor_47k_active,
   // interrupt pin
   output logic irq_out
);
   import pmicir_pkg::*;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] t);
      hit = (a == t);
   endfunction

   function automatic logic [6:0] dog_len(input logic p64);
      dog_len = p64 ? `PMICIR_DOG_P64_SEC : `PMICIR_DOG_P32_SEC;
   endfunction

   function automatic logic [6:0] dog_lead(input logic p64);
      dog_lead = p64 ? `PMICIR_DOG_LEAD64_SEC : `PMICIR_DOG_LEAD32_SEC;
   endfunction

   pmicir_state_t state_r;
   logic restore_now;
   logic [7:0] chg_en_r;
   logic [2:0] bl_en_r;
   logic ntc_sel_r;
   logic [7:0] chg_flags;
   logic [2:0] bl_flags;
   logic [7:0] chg_set;
   logic [2:0] bl_set;
   logic chg_rd_clr;
   logic bl_rd_clr;
   logic die_temp_d_r;
   logic dog_alarm_r;
   logic [31:0] tick_cnt_r;
   logic sec_tick;
   logic [6:0] sec_cnt_r;
   logic [7:0] rdata_nxt;

   assign restore_now = (state_r == PMICIR_ST_RESTORE);

   // restore sequencer
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         state_r <= PMICIR_ST_RUN;
      end else begin
         case (state_r)
            PMICIR_ST_RUN: begin
               if (reg_wr && hit(reg_addr, `PMICIR_ADDR_RESTORE) &&
                   reg_wdata == `PMICIR_RESTORE_KEY) begin
                  state_r <= PMICIR_ST_RESTORE; // RULE9
               end
            end
            PMICIR_ST_RESTORE: begin
               state_r <= PMICIR_ST_RUN;
            end
            default: begin
               state_r <= PMICIR_ST_RUN;
            end
         endcase
      end
   end

   // charger enables
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         chg_en_r <= `PMICIR_RST_CHG_EN; // RULE2
      end else if (restore_now) begin
         chg_en_r <= `PMICIR_RST_CHG_EN; // RULE9
      end else if (reg_wr && hit(reg_addr, `PMICIR_ADDR_CHG_EN)) begin
         chg_en_r <= reg_wdata; // RULE1 RULE2
      end
   end

   // boost/ldo enables, upper bits not stored
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         bl_en_r <= `PMICIR_RST_BL_EN;
      end else if (restore_now) begin
         bl_en_r <= `PMICIR_RST_BL_EN; // RULE9
      end else if (reg_wr && hit(reg_addr, `PMICIR_ADDR_BL_EN)) begin
         bl_en_r <= reg_wdata[`PMICIR_BL_W-1:0]; // RULE7
      end
   end

   // thermistor select
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         ntc_sel_r <= `PMICIR_RST_NTC;
      end else if (restore_now) begin
         ntc_sel_r <= `PMICIR_RST_NTC; // RULE9
      end else if (reg_wr && hit(reg_addr, `PMICIR_ADDR_NTC)) begin
         ntc_sel_r <= reg_wdata[0]; // RULE10
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         thermistor_47k_active <= 1'b0;
      end else begin
         thermistor_47k_active <= ntc_sel_r & external_thermistor_mode; // RULE10
      end
   end

   // watchdog second prescaler
   assign sec_tick = (tick_cnt_r == 32'(TICKS_PER_SEC - 1));

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         tick_cnt_r <= '0;
      end else if (dog_kick || sec_tick) begin
         tick_cnt_r <= '0;
      end else begin
         tick_cnt_r <= tick_cnt_r + 32'h1;
      end
   end

   // watchdog seconds, alarm ahead of expiry
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         sec_cnt_r <= '0;
         dog_alarm_r <= 1'b0;
         dog_expired <= 1'b0;
      end else begin
         dog_alarm_r <= 1'b0;
         dog_expired <= 1'b0;
         if (dog_kick) begin
            sec_cnt_r <= '0;
         end else if (sec_tick) begin
            if (sec_cnt_r + 7'h1 >= dog_len(dog_period_64)) begin
               sec_cnt_r <= '0;
               dog_expired <= 1'b1;
            end else begin
               sec_cnt_r <= sec_cnt_r + 7'h1;
            end
            if (sec_cnt_r + 7'h1 == dog_len(dog_period_64) -
                dog_lead(dog_period_64)) begin
               dog_alarm_r <= 1'b1; // RULE5
            end
         end
      end
   end

   // die warning edge
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         die_temp_d_r <= 1'b0;
      end else begin
         die_temp_d_r <= die_temp_warn;
      end
   end

   // event sources gated by their enables
   always_comb begin
      chg_set = chg_event_in;
      chg_set[`PMICIR_BIT_DOG] = dog_alarm_r;
      chg_set[`PMICIR_BIT_OVT] = die_temp_warn & ~die_temp_d_r; // RULE6
      chg_set = chg_set & chg_en_r; // RULE3 RULE6
      bl_set = bl_event_in & bl_en_r; // RULE7 RULE8
   end

   assign chg_rd_clr = restore_now ||
                       (reg_rd && hit(reg_addr, `PMICIR_ADDR_CHG_FLAG));
   assign bl_rd_clr = restore_now ||
                      (reg_rd && hit(reg_addr, `PMICIR_ADDR_BL_FLAG));

   pmicir_flags #(.W(`PMICIR_CHG_W)) u_chg_flags (
      .core_clk(core_clk),
      .rstn(rstn),
      .set_in(chg_set),
      .clr_in(chg_rd_clr), // RULE4
      .flags(chg_flags)
   );

   pmicir_flags #(.W(`PMICIR_BL_W)) u_bl_flags (
      .core_clk(core_clk),
      .rstn(rstn),
      .set_in(bl_set),
      .clr_in(bl_rd_clr), // RULE4
      .flags(bl_flags)
   );

   // read mux, unmapped and write-only read zero
   always_comb begin
      rdata_nxt = 8'h00;
      case (reg_addr)
         `PMICIR_ADDR_CHG_EN: rdata_nxt = chg_en_r;
         `PMICIR_ADDR_CHG_FLAG: rdata_nxt = chg_flags;
         `PMICIR_ADDR_BL_EN: rdata_nxt = {5'h00, bl_en_r};
         `PMICIR_ADDR_BL_FLAG: rdata_nxt = {5'h00, bl_flags}; // RULE8
         `PMICIR_ADDR_NTC: rdata_nxt = {7'h00, ntc_sel_r};
         default: rdata_nxt = 8'h00;
      endcase
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         reg_rdata <= 8'h00;
         reg_rvalid <= 1'b0;
      end else begin
         reg_rvalid <= reg_rd;
         if (reg_rd) begin
            reg_rdata <= rdata_nxt;
         end
      end
   end

   // interrupt pin
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         irq_out <= 1'b0;
      end else begin
         irq_out <= |(chg_flags & chg_en_r) | |(bl_flags & bl_en_r); // RULE11
      end
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rstn);

   chk_gated_set: assert property ( // RULE3
      (chg_event_in[0] && !chg_en_r[0]) |=> !chg_flags[0] || $past(chg_flags[0]))
      else $error("disabled source set a flag");
   chk_flag_sets: assert property ( // RULE3
      (chg_event_in[7] && chg_en_r[7]) |=> chg_flags[7])
      else $error("enabled event did not set flag");
   chk_bl_high_zero: assert property ( // RULE8
      reg_rvalid && $past(reg_addr) == `PMICIR_ADDR_BL_FLAG |->
      reg_rdata[7:3] == 5'h00)
      else $error("unused bits not zero");
   chk_restore_seq: assert property ( // RULE9
      (reg_wr && reg_addr == `PMICIR_ADDR_RESTORE &&
       reg_wdata == `PMICIR_RESTORE_KEY && state_r == PMICIR_ST_RUN) |=>
      restore_now ##1 (chg_en_r == 8'h00 && bl_en_r == 3'h0 && ntc_sel_r))
      else $error("restore did not return defaults");
   chk_ntc_gate: assert property ( // RULE10
      !external_thermistor_mode |=> !thermistor_47k_active)
      else $error("thermistor select active outside mode");
   chk_irq_follow: assert property ( // RULE11
      ((chg_flags & chg_en_r) != 8'h00) |=> irq_out)
      else $error("interrupt not raised");
   chk_irq_release: assert property ( // RULE11
      ((chg_flags & chg_en_r) == 8'h00 && (bl_flags & bl_en_r) == 3'h0)
      |=> !irq_out)
      else $error("interrupt not released");
   chk_alarm_lead: assert property ( // RULE5
      dog_alarm_r |-> (sec_cnt_r ==
      dog_len(dog_period_64) - dog_lead(dog_period_64)))
      else $error("alarm at wrong second");
   chk_alarm_flag: assert property ( // RULE5
      (dog_alarm_r && chg_en_r[`PMICIR_BIT_DOG]) |=>
      chg_flags[`PMICIR_BIT_DOG])
      else $error("watchdog alarm flag missing");
   chk_ovt_edge: assert property ( // RULE6
      (die_temp_warn && !die_temp_d_r && chg_en_r[`PMICIR_BIT_OVT]) |=>
      chg_flags[`PMICIR_BIT_OVT])
      else $error("overtemperature flag missing");
   chk_bl_gated: assert property ( // RULE7
      (bl_event_in[0] && !bl_en_r[0]) |=> !bl_flags[0] || $past(bl_flags[0]))
      else $error("disabled boost ldo source set a flag");
   chk_bl_flag_sets: assert property ( // RULE8
      (bl_event_in[2] && bl_en_r[2]) |=> bl_flags[2])
      else $error("enabled boost ldo event did not set flag");
   chk_flag_read_clr: assert property ( // RULE4
      (reg_rd && reg_addr == `PMICIR_ADDR_CHG_FLAG && chg_set == 8'h00) |=>
      (chg_flags == 8'h00))
      else $error("charger flags not cleared by read");
   chk_irq_bl_follow: assert property ( // RULE11
      ((bl_flags & bl_en_r) != 3'h0) |=> irq_out)
      else $error("boost ldo interrupt not raised");
   chk_restore_clears: assert property ( // RULE9
      restore_now |=>
      (chg_flags == $past(chg_set) && bl_flags == $past(bl_set)))
      else $error("restore did not clear flags");
   chk_ntc_follow: assert property ( // RULE10
      (external_thermistor_mode && ntc_sel_r) |=> thermistor_47k_active)
      else $error("thermistor select not applied in mode");
   chk_en_write: assert property ( // RULE1
      (reg_wr && reg_addr == `PMICIR_ADDR_CHG_EN && !restore_now) |=>
      (chg_en_r == $past(reg_wdata)))
      else $error("charger enable write lost");
endmodule // pmicir_top
`default_nettype wire
